// ---- logic/pscc_params.svh ----
// Constants for the PHY symbol error tally and special control bank.
// Assumes a 5-bit management index and 16-bit register data.
// Operation
// - On the 100 Mb/s receive path every invalid code symbol in idle advances the tally, and the first one of each packet.
// - The tally advances at most once for each received packet.
// - The tally is an unsigned 16-bit field that wraps to zero past its maximum.
// - Reset clears the tally and a read leaves it unchanged.
// - The tally holds still while the port runs at 10 Mb/s.
// - The tally sits at index 26, is 16 bits wide and read-only.
// - The special control register sits at index 27 and is 16 bits wide.
// - With the source select bit 15 at its reset value zero the straps set the crossover mode.
// - With the source select bit one the straps are ignored and bits 14 and 13 set the mode.
// - Bit 11 set suppresses the heartbeat test; zero, its reset value, permits it.
// - Bit 5 set enables both generation and detection of far-end fault.
// - Register mode 00 is straight, 01 crossover, 10 automatic and 11 reserved.
// - The far-end fault bit resets to one on a fiber port and to zero otherwise.
// - A PHY reset with the soft reset bit set returns the clearable control bits to defaults.
`ifndef PSCC_PARAMS_SVH
`define PSCC_PARAMS_SVH

`define PSCC_ADDR_W        5
`define PSCC_DATA_W        16
`define PSCC_IDX_TALLY     5'h1a
`define PSCC_IDX_SPECIAL   5'h1b
`define PSCC_BIT_SRC_SEL   15
`define PSCC_BIT_AUTO_EN   14
`define PSCC_BIT_MAN_STATE 13
`define PSCC_BIT_SQE_OFF   11
`define PSCC_BIT_FEFI      5
`define PSCC_TALLY_RST     16'h0000
`define PSCC_TALLY_MAX     16'hffff
`define PSCC_CTRL_BIT_RST  1'b0
`define PSCC_RSVD_MASK     16'h17df
`define PSCC_RD_IDLE       16'h0000

`endif

// ---- logic/pscc_pkg.sv ----
// Types shared by the symbol error tally and special control bank.
// Assumes the constants header is compiled alongside.
package pscc_pkg;

    // Crossover mode handed to the analog front end
    typedef enum logic [1:0] {
        PSCC_MDIX_STRAIGHT = 2'h0,
        PSCC_MDIX_CROSS    = 2'h1,
        PSCC_MDIX_AUTO     = 2'h3,
        PSCC_MDIX_RSVD     = 2'h2
    } pscc_mdix_t;

    // Receive framing seen by the tally
    typedef enum logic [1:0] {
        PSCC_RX_IDLE    = 2'h0,
        PSCC_RX_PKT     = 2'h1,
        PSCC_RX_COUNTED = 2'h3
    } pscc_rx_state_t;

endpackage

// ---- logic/pscc_tally.sv ----
// Symbol error tally with once-per-packet gating.
// Assumes receive indications are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_params.svh"

module pscc_tally (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Receive path
    input  wire logic        rxSymbolError,
    input  wire logic        rxPacketActive,
    input  wire logic        speed100,
    // Results
    output logic [15:0]      tally,
    output logic             pktCounted
);
    import pscc_pkg::*;

    pscc_rx_state_t state_q;
    pscc_rx_state_t state_d;
    logic           incr;

    // Idle errors count every time; inside a packet only the first
    assign incr = speed100 && rxSymbolError
                  && !(state_q == PSCC_RX_COUNTED && rxPacketActive);
    assign pktCounted = (state_q == PSCC_RX_COUNTED);

    always_comb begin
        state_d = state_q;
        case (state_q)
            PSCC_RX_IDLE: begin
                if (rxPacketActive)
                    state_d = incr ? PSCC_RX_COUNTED : PSCC_RX_PKT;
            end
            PSCC_RX_PKT: begin
                if (!rxPacketActive)
                    state_d = PSCC_RX_IDLE;
                else if (incr)
                    state_d = PSCC_RX_COUNTED;
            end
            PSCC_RX_COUNTED: begin
                if (!rxPacketActive)
                    state_d = PSCC_RX_IDLE;
            end
            default: state_d = PSCC_RX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            state_q <= PSCC_RX_IDLE;
        else
            state_q <= state_d;
    end

    // Plain 16-bit add rolls over to zero by itself
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            tally <= `PSCC_TALLY_RST;
        else if (incr)
            tally <= tally + 16'h0001;
    end

endmodule
`default_nettype wire

// ---- logic/pscc_mdix_sel.sv ----
// Crossover mode selection between straps and register bits.
// Assumes straps are stable levels.
`timescale 1ns/1ps
`default_nettype none

module pscc_mdix_sel (
    // Register bits
    input  wire logic            srcSel,
    input  wire logic            autoEn,
    input  wire logic            manState,
    // Straps
    input  wire logic            autoMdixStrap,
    input  wire logic            manualMdixStrap,
    // Mode
    output pscc_pkg::pscc_mdix_t mdixMode
);
    import pscc_pkg::*;

    always_comb begin
        if (!srcSel) begin
            // Auto strap overrides the manual one
            if (autoMdixStrap)
                mdixMode = PSCC_MDIX_AUTO;
            else
                mdixMode = manualMdixStrap ? PSCC_MDIX_CROSS : PSCC_MDIX_STRAIGHT;
        end else begin
            case ({autoEn, manState})
                2'h0:    mdixMode = PSCC_MDIX_STRAIGHT;
                2'h1:    mdixMode = PSCC_MDIX_CROSS;
                2'h2:    mdixMode = PSCC_MDIX_AUTO;
                default: mdixMode = PSCC_MDIX_RSVD;
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- logic/pscc_regs.sv ----
// Register bank: symbol error tally and special control register.
// Assumes a single-cycle strobe port and straps stable after reset.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_params.svh"

module pscc_regs (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // Register port
    input  wire logic [4:0]      regAddr,
    input  wire logic [15:0]     regWrData,
    input  wire logic            regWrEn,
    input  wire logic            regRdEn,
    output logic [15:0]          regRdData,
    // PHY reset request
    input  wire logic            softResetReq,
    input  wire logic            phySoftResetBit,
    // Straps
    input  wire logic            autoMdixStrap,
    input  wire logic            manualMdixStrap,
    input  wire logic            fxModeStrap,
    // Receive path
    input  wire logic            rxSymbolError,
    input  wire logic            rxPacketActive,
    input  wire logic            speed100,
    // Controls to the PHY
    output pscc_pkg::pscc_mdix_t mdixMode,
    output logic                 heartbeatTestDisable,
    output logic                 farEndFaultGenEn,
    output logic                 farEndFaultDetEn
);
    import pscc_pkg::*;

    logic        srcSel_q;
    logic        autoEn_q;
    logic        manState_q;
    logic        heartbeat_test_disable_q;
    logic        fefi_q;
    logic        strapLoaded_q;
    logic [15:0] tally;
    logic        pktCounted;
    logic        wrSpecial;
    logic        rdTally;
    logic        rdSpecial;
    logic        softClear;
    logic [15:0] specialView;
    logic [15:0] rdData_d;

    assign wrSpecial = regWrEn && (regAddr == `PSCC_IDX_SPECIAL);
    assign rdTally   = regRdEn && (regAddr == `PSCC_IDX_TALLY);
    assign rdSpecial = regRdEn && (regAddr == `PSCC_IDX_SPECIAL);
    // Soft reset only matters with the basic control soft reset bit set
    assign softClear = softResetReq && phySoftResetBit;

    pscc_tally u_tally (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .rxSymbolError  (rxSymbolError),
        .rxPacketActive (rxPacketActive),
        .speed100       (speed100),
        .tally          (tally),
        .pktCounted     (pktCounted)
    );

    pscc_mdix_sel u_mdix (
        .srcSel          (srcSel_q),
        .autoEn          (autoEn_q),
        .manState        (manState_q),
        .autoMdixStrap   (autoMdixStrap),
        .manualMdixStrap (manualMdixStrap),
        .mdixMode        (mdixMode)
    );

    // Crossover control bits; soft reset beats a same-cycle write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcSel_q   <= `PSCC_CTRL_BIT_RST;
            autoEn_q   <= `PSCC_CTRL_BIT_RST;
            manState_q <= `PSCC_CTRL_BIT_RST;
        end else if (softClear) begin
            srcSel_q   <= `PSCC_CTRL_BIT_RST;
            autoEn_q   <= `PSCC_CTRL_BIT_RST;
            manState_q <= `PSCC_CTRL_BIT_RST;
        end else if (wrSpecial) begin
            srcSel_q   <= regWrData[`PSCC_BIT_SRC_SEL];
            autoEn_q   <= regWrData[`PSCC_BIT_AUTO_EN];
            manState_q <= regWrData[`PSCC_BIT_MAN_STATE];
        end
    end

    // Heartbeat test suppression
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            heartbeat_test_disable_q <= `PSCC_CTRL_BIT_RST;
        else if (softClear)
            heartbeat_test_disable_q <= `PSCC_CTRL_BIT_RST;
        else if (wrSpecial)
            heartbeat_test_disable_q <= regWrData[`PSCC_BIT_SQE_OFF];
    end

    // Fiber strap caught once after release, never inside the async reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            strapLoaded_q <= 1'b0;
        else
            strapLoaded_q <= 1'b1;
    end

    // Far-end fault bit is not soft-reset-clearable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            fefi_q <= `PSCC_CTRL_BIT_RST;
        else if (!strapLoaded_q)
            fefi_q <= fxModeStrap;
        else if (wrSpecial)
            fefi_q <= regWrData[`PSCC_BIT_FEFI];
    end

    assign heartbeatTestDisable = heartbeat_test_disable_q;
    assign farEndFaultGenEn     = fefi_q;
    assign farEndFaultDetEn     = fefi_q;

    // Reserved bits stay zero; nothing stores them
    always_comb begin
        specialView                      = 16'h0000;
        specialView[`PSCC_BIT_SRC_SEL]   = srcSel_q;
        specialView[`PSCC_BIT_AUTO_EN]   = autoEn_q;
        specialView[`PSCC_BIT_MAN_STATE] = manState_q;
        specialView[`PSCC_BIT_SQE_OFF]   = heartbeat_test_disable_q;
        specialView[`PSCC_BIT_FEFI]      = fefi_q;
    end

    // Unmapped indices and idle cycles return zero
    always_comb begin
        rdData_d = `PSCC_RD_IDLE;
        if (rdTally)
            rdData_d = tally;
        else if (rdSpecial)
            rdData_d = specialView;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            regRdData <= `PSCC_RD_IDLE;
        else
            regRdData <= rdData_d;
    end

    // Tally stays put at 10 Mb/s whatever arrives
    a_tally_hold_slow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !speed100 |=> $stable(tally)
    ) else $error("tally moved in 10 Mb/s mode");

    // Idle error at 100 Mb/s adds exactly one
    a_tally_idle_step: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (speed100 && rxSymbolError && !rxPacketActive)
        |=> tally == $past(tally) + 16'h0001
    ) else $error("idle symbol error not counted");

    // Second error in the same packet leaves the tally alone
    a_tally_once_pkt: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (pktCounted && rxPacketActive && rxSymbolError)
        |=> $stable(tally)
    ) else $error("tally counted a packet twice");

    // First error of a packet is counted and then the packet is marked
    a_tally_first_err: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (speed100 && rxPacketActive && rxSymbolError && !pktCounted)
        |=> (tally == $past(tally) + 16'h0001) && pktCounted
    ) else $error("first packet error missed");

    // Counting past the top rolls to zero
    a_tally_wrap_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tally == `PSCC_TALLY_MAX && speed100 && rxSymbolError && !rxPacketActive)
        |=> tally == `PSCC_TALLY_RST
    ) else $error("tally did not wrap");

    // A read returns the count and does not disturb it
    a_tally_read_keep: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdTally && !rxSymbolError)
        |=> (regRdData == $past(tally)) && $stable(tally)
    ) else $error("tally read wrong or disturbed");

    // Writes to the tally index change nothing
    a_tally_ro_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regWrEn && regAddr == `PSCC_IDX_TALLY && !rxSymbolError)
        |=> $stable(tally)
    ) else $error("tally accepted a write");

    // Written control bits read back, reserved bits zero
    a_special_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrSpecial && !softClear && strapLoaded_q) ##1 rdSpecial
        |=> regRdData == ($past(regWrData, 2) & 16'he820)
    ) else $error("special register readback mismatch");

    // Straps decide while the source select is clear
    a_mode_from_strap: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !srcSel_q |-> mdixMode == (autoMdixStrap ? PSCC_MDIX_AUTO :
                       manualMdixStrap ? PSCC_MDIX_CROSS : PSCC_MDIX_STRAIGHT)
    ) else $error("strap crossover mode wrong");

    // Register bits decide once source select is written
    a_mode_from_reg: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrSpecial && !softClear && regWrData[15:13] == 3'h6)
        |=> mdixMode == PSCC_MDIX_AUTO
    ) else $error("register crossover mode wrong");

    // Manual crossover selected by state bit alone
    a_mode_reg_cross: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (srcSel_q && !autoEn_q && manState_q) |-> mdixMode == PSCC_MDIX_CROSS
    ) else $error("manual crossover not selected");

    // Heartbeat suppression follows bit 11 one cycle after the write
    a_sqe_follow_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrSpecial && !softClear)
        |=> heartbeatTestDisable == $past(regWrData[`PSCC_BIT_SQE_OFF])
    ) else $error("heartbeat disable not following write");

    // Both far-end fault enables follow bit 5
    a_fefi_both_dirs: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrSpecial && strapLoaded_q)
        |=> farEndFaultGenEn == $past(regWrData[`PSCC_BIT_FEFI])
            && farEndFaultDetEn == $past(regWrData[`PSCC_BIT_FEFI])
    ) else $error("far-end fault enables wrong");

    // Far-end fault default follows the fiber strap
    a_fefi_strap_dflt: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        // Sampled reset keeps the release edge itself out of it
        (rst_n && !strapLoaded_q) |=> farEndFaultGenEn == $past(fxModeStrap)
    ) else $error("far-end fault default wrong");

    // Soft reset clears the clearable bits and spares far-end fault
    a_soft_clear_bits: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (softClear && strapLoaded_q && !wrSpecial)
        |=> !srcSel_q && !autoEn_q && !manState_q && !heartbeat_test_disable_q
            && $stable(fefi_q)
    ) else $error("soft reset did not clear control bits");

    // Soft reset request without the soft reset bit is ignored
    a_soft_gated: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (softResetReq && !phySoftResetBit && !wrSpecial)
        |=> $stable(srcSel_q) && $stable(heartbeat_test_disable_q)
    ) else $error("soft reset acted without soft reset bit");

    // Tally moves only on a 100 Mb/s symbol error
    a_tally_err_only: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(speed100 && rxSymbolError)
        |=> $stable(tally)
    ) else $error("tally moved without a symbol error");

    // A low cycle on packet activity re-arms the per-packet count
    a_tally_pkt_rearm: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !rxPacketActive |=> !pktCounted
    ) else $error("packet count not re-armed");

    // Register mode 00 selects the straight pairing
    a_mode_reg_straight: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (srcSel_q && !autoEn_q && !manState_q) |-> mdixMode == PSCC_MDIX_STRAIGHT
    ) else $error("manual straight not selected");

    // Register mode 10 selects automatic crossover whatever the straps say
    a_mode_reg_auto: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (srcSel_q && autoEn_q && !manState_q) |-> mdixMode == PSCC_MDIX_AUTO
    ) else $error("automatic crossover not selected");

    // Reserved code 11 never looks like a usable mode
    a_mode_reg_rsvd: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (srcSel_q && autoEn_q && manState_q) |-> mdixMode == PSCC_MDIX_RSVD
    ) else $error("reserved crossover code not flagged");

    // Reserved bits of the special control register always read zero
    a_special_rsvd_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rdSpecial
        |=> (regRdData & `PSCC_RSVD_MASK) == 16'h0000
    ) else $error("reserved control bits read nonzero");

    // Reads of other indices and idle cycles return zero
    a_unmapped_read_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!rdTally && !rdSpecial)
        |=> regRdData == `PSCC_RD_IDLE
    ) else $error("read data not zero outside a mapped read");

endmodule
`default_nettype wire

// ---- dv/pscc_link_partner.sv ----
// Cable-side partner: delivers receive indications with symbol errors.
// Assumes sys_clk is the PHY clock; driven at rising edges only.
`timescale 1ns/1ps
`default_nettype none

module pscc_link_partner (
    // Clock
    input  wire logic sys_clk,
    // Receive indications
    output logic      rxSymbolError,
    output logic      rxPacketActive
);
    initial begin
        rxSymbolError  = 1'b0;
        rxPacketActive = 1'b0;
    end

    // One packet of len cycles, errors in the first nErr of them
    task automatic pkt(input int len, input int nErr);
        for (int i = 0; i < len; i++) begin
            @(posedge sys_clk);
            rxPacketActive <= 1'b1;
            rxSymbolError  <= (i < nErr);
        end
        @(posedge sys_clk);
        rxPacketActive <= 1'b0;
        rxSymbolError  <= 1'b0;
        // Low cycle closes the packet before anything else
        @(posedge sys_clk);
    endtask

    // Invalid symbols between packets, one per cycle
    task automatic idle_err(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            rxSymbolError <= 1'b1;
        end
        @(posedge sys_clk);
        rxSymbolError <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- dv/phy_symerr_crossover_ctrl_tb_top.sv ----
// Self-checking bench for the symbol error tally and special control bank.
// Assumes a partner model on the receive path and the strobe register port.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_params.svh"

module phy_symerr_crossover_ctrl_tb_top;
    import pscc_pkg::*;
    logic                 sys_clk, rst_n, regWrEn, regRdEn;
    logic [4:0]           regAddr;
    logic [15:0]          regWrData, regRdData;
    logic                 softResetReq, phySoftResetBit, speed100;
    logic                 autoMdixStrap, manualMdixStrap, fxModeStrap;
    logic                 rxSymbolError, rxPacketActive;
    logic                 hbOff, fefGen, fefDet;
    pscc_mdix_t           mdixMode;
    int                   fails, nCompared;
    logic [15:0]          expTally;

    pscc_link_partner lp (.sys_clk(sys_clk), .rxSymbolError(rxSymbolError),
        .rxPacketActive(rxPacketActive));

    pscc_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .softResetReq(softResetReq),
        .phySoftResetBit(phySoftResetBit), .autoMdixStrap(autoMdixStrap),
        .manualMdixStrap(manualMdixStrap), .fxModeStrap(fxModeStrap),
        .rxSymbolError(rxSymbolError), .rxPacketActive(rxPacketActive),
        .speed100(speed100), .mdixMode(mdixMode), .heartbeatTestDisable(hbOff),
        .farEndFaultGenEn(fefGen), .farEndFaultDetEn(fefDet));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches=%0d compared=%0d", fails, nCompared);
        if (fails == 0 && nCompared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask

    // Write then read back with no idle cycle between the strobes
    task automatic wrrd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(posedge sys_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask

    task automatic do_reset(input logic fx);
        @(posedge sys_clk);
        fxModeStrap <= fx;
        rst_n       <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        expTally = 16'h0000;
    endtask

    // Straps drive the mode while source select is clear
    task automatic t_straps();
        logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {autoMdixStrap, manualMdixStrap} <= i[1:0];
            @(posedge sys_clk);
            #1;
            chk({14'h0, mdixMode}, {14'h0, exp[i]});
        end
    endtask

    // Register mode overrides straps; all four codes
    task automatic t_regmode();
        logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {autoMdixStrap, manualMdixStrap} <= ~i[1:0];
            wr(`PSCC_IDX_SPECIAL, {1'b1, i[1:0], 13'h0});
            chk({14'h0, mdixMode}, {14'h0, exp[i]});
        end
        wr(`PSCC_IDX_SPECIAL, 16'hffff);
        chk({13'h0, hbOff, fefGen, fefDet}, 16'h0007);
        rdchk(`PSCC_IDX_SPECIAL, 16'he820);
        wr(`PSCC_IDX_SPECIAL, 16'h0000);
        chk({13'h0, hbOff, fefGen, fefDet}, 16'h0000);
        rdchk(`PSCC_IDX_SPECIAL, 16'h0000);
    endtask

    // Once per packet, idle errors, no count at 10 Mb/s, read-only
    task automatic t_tally();
        lp.pkt(6, 3);
        lp.pkt(4, 1);
        expTally += 16'h0002;
        rdchk(`PSCC_IDX_TALLY, expTally);
        lp.idle_err(3);
        expTally += 16'h0003;
        rdchk(`PSCC_IDX_TALLY, expTally);
        rdchk(`PSCC_IDX_TALLY, expTally);
        @(posedge sys_clk);
        speed100 <= 1'b0;
        lp.pkt(4, 4);
        lp.idle_err(5);
        speed100 <= 1'b1;
        rdchk(`PSCC_IDX_TALLY, expTally);
        wr(`PSCC_IDX_TALLY, 16'h1234);
        wr(5'h1c, 16'hffff);
        rdchk(`PSCC_IDX_TALLY, expTally);
        rdchk(5'h1c, 16'h0000);
    endtask

    // Count to the top and one past it
    task automatic t_wrap();
        lp.idle_err(int'(16'hffff - expTally));
        rdchk(`PSCC_IDX_TALLY, 16'hffff);
        lp.idle_err(1);
        rdchk(`PSCC_IDX_TALLY, 16'h0000);
    endtask

    // Soft reset needs the gate bit; fault enable keeps its value
    task automatic t_soft();
        wrrd(`PSCC_IDX_SPECIAL, 16'hffff, 16'he820);
        @(posedge sys_clk);
        softResetReq <= 1'b1;
        @(posedge sys_clk);
        softResetReq <= 1'b0;
        rdchk(`PSCC_IDX_SPECIAL, 16'he820);
        @(posedge sys_clk);
        softResetReq    <= 1'b1;
        phySoftResetBit <= 1'b1;
        @(posedge sys_clk);
        softResetReq    <= 1'b0;
        phySoftResetBit <= 1'b0;
        rdchk(`PSCC_IDX_SPECIAL, 16'h0020);
    endtask

    initial begin
        {regWrEn, regRdEn, softResetReq, phySoftResetBit} = 4'h0;
        {autoMdixStrap, manualMdixStrap} = 2'h0;
        regAddr   = 5'h00;
        regWrData = 16'h0000;
        speed100  = 1'b1;
        fails     = 0;
        nCompared = 0;
        rst_n       = 1'b0;
        fxModeStrap = 1'b1;
        do_reset(1'b1);
        rdchk(`PSCC_IDX_TALLY, 16'h0000);
        rdchk(`PSCC_IDX_SPECIAL, 16'h0020);
        t_wrap();
        t_tally();
        // Tally left nonzero so the second reset has something to clear
        do_reset(1'b0);
        rdchk(`PSCC_IDX_SPECIAL, 16'h0000);
        rdchk(`PSCC_IDX_TALLY, 16'h0000);
        // Automatic crossover only ever written on the copper port
        t_straps();
        t_regmode();
        t_soft();
        tally_and_finish();
    end

    // Hang guard
    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
